// File: core/ctpd_pkg.sv
// Package: register map, field layout, reset values and carriers for the clock trim slice
package ctpd_pkg;

    // Register addresses, 8-bit register index space
    localparam logic [7:0]  ADDR_SAMPLE_TRIM = 8'h4b;
    localparam logic [7:0]  ADDR_TIMING_TRIM = 8'h4d;
    localparam logic [7:0]  ADDR_PIN_DIR     = 8'h4f;

    // Field positions
    localparam int SAMPLE_TRIM_LSB = 0;
    localparam int SAMPLE_TRIM_W   = 6;
    localparam int TIMING_TRIM_LSB = 0;
    localparam int TIMING_TRIM_W   = 8;
    localparam int PIN1_OE_BIT     = 6;
    localparam int PIN1_IE_BIT     = 5;
    localparam int BYPASS_BIT      = 8;

    // Reset values of whole registers, reserved bits included
    localparam logic [15:0] SAMPLE_TRIM_RST = 16'h2612;
    localparam logic [15:0] TIMING_TRIM_RST = 16'h0098;
    localparam logic [15:0] PIN_DIR_RST     = 16'h2090;
    localparam logic [15:0] READ_ZERO       = 16'h0000;

    // Trim step sizes in tenths of Hz, millihertz and kHz, for reference by models
    localparam int SAMPLE_STEP_HZ_X10     = 6000;
    localparam int SAMPLE_RATE_STEP_MHZ   = 1900;
    localparam int TIMING_STEP_KHZ        = 109;
    localparam logic [5:0] SAMPLE_TRIM_CENTRE = 6'h22;

    // Register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } ctpd_req_t;

    // Configuration handed to the oscillators and the pin
    typedef struct packed {
        logic [5:0] sample_clock_trim;
        logic [7:0] timing_clock_trim;
        logic       sample_oscillator_bypass;
        logic       aux_pin1_output_enable;
        logic       aux_pin1_input_enable;
    } ctpd_cfg_t;

endpackage : ctpd_pkg

// File: core/ctpd_reg16.sv
// One 16-bit software register with reset value and write strobe
`timescale 1ns/1ns
module ctpd_reg16 #(
    parameter logic [15:0] RST = 16'h0000
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        we_i,
    input  wire logic [15:0] d_i,
    output logic      [15:0] q_o
);
    logic [15:0] val_reg;
    logic [15:0] val_next;

    // Next value: load on strobe, else hold
    always_comb
    begin
        val_next = val_reg;
        if (we_i)
        begin
            val_next = d_i;
        end
    end

    // Synchronous reset to the documented value
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            val_reg <= RST;
        end
        else
        begin
            val_reg <= val_next;
        end
    end

    assign q_o = val_reg;
endmodule : ctpd_reg16

// File: core/ctpd_top.sv
// Top: clock trim registers, pin 1 direction and oscillator control outputs
// How it works
// - Six-bit slow clock trim, reset 0x12, about 0.6 kHz per step.
// - Slow trim inverse: zero fastest, 100010 centre, all ones slowest.
// - At 100 Hz sample rate one slow trim step moves rate 1.9 Hz.
// - Eight-bit fast clock trim, reset 0x98, about 109 kHz per step.
// - Fast trim direct: zero slowest, 10011000 default, all ones fastest.
// - Bit 6 of pin register enables pin 1 driver, reset off.
// - Bit 5 of pin register enables pin 1 input buffer, reset off.
`timescale 1ns/1ns
module ctpd_top (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    output logic      [5:0]  sample_clock_trim_o,
    output logic      [5:0]  sample_osc_speed_o,
    output logic      [7:0]  timing_clock_trim_o,
    output logic             sample_oscillator_bypass_o,
    output logic             sample_clock_ext_ok_o,
    input  wire logic        aux_pin_one_i,
    output logic             aux_pin_one_o,
    output logic             aux_pin_one_oe_o,
    output logic             aux_pin_one_in_o
);
    ctpd_pkg::ctpd_req_t req;
    ctpd_pkg::ctpd_cfg_t cfg;
    logic [15:0] sample_q;
    logic [15:0] timing_q;
    logic [15:0] pin_q;
    logic        we_sample;
    logic        we_timing;
    logic        we_pin;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic        pin_sync1_reg;
    logic        pin_sync2_reg;
    logic        pin_in_reg;
    logic        pin_in_next;
    logic        pin_oe_reg;
    logic        cfg_ext_reg;
    logic        cfg_ext_next;
    logic [5:0]  speed_reg;
    logic [5:0]  speed_next;

    assign req.addr  = addr_i;
    assign req.wdata = wdata_i;
    assign req.wr    = wr_i;
    assign req.rd    = rd_i;

    // Write decode; whole words stored so reserved bits read back as written
    always_comb
    begin
        we_sample = 1'b0;
        we_timing = 1'b0;
        we_pin    = 1'b0;
        if (req.wr && req.addr == ctpd_pkg::ADDR_SAMPLE_TRIM)
        begin
            we_sample = 1'b1;
        end
        else if (req.wr && req.addr == ctpd_pkg::ADDR_TIMING_TRIM)
        begin
            we_timing = 1'b1;
        end
        else if (req.wr && req.addr == ctpd_pkg::ADDR_PIN_DIR)
        begin
            we_pin = 1'b1;
        end
    end

    // Slow clock trim register, reset keeps 0x12 in the low field
    ctpd_reg16 #(.RST(ctpd_pkg::SAMPLE_TRIM_RST)) u_sample (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .we_i   (we_sample),
        .d_i    (req.wdata),
        .q_o    (sample_q)
    );

    // Fast clock trim register, reset 0x98
    ctpd_reg16 #(.RST(ctpd_pkg::TIMING_TRIM_RST)) u_timing (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .we_i   (we_timing),
        .d_i    (req.wdata),
        .q_o    (timing_q)
    );

    // Pin direction register, both enables clear at reset
    ctpd_reg16 #(.RST(ctpd_pkg::PIN_DIR_RST)) u_pin (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .we_i   (we_pin),
        .d_i    (req.wdata),
        .q_o    (pin_q)
    );

    // Field extraction into the configuration carrier
    assign cfg.sample_clock_trim        = sample_q[ctpd_pkg::SAMPLE_TRIM_LSB +: ctpd_pkg::SAMPLE_TRIM_W];
    assign cfg.timing_clock_trim        = timing_q[ctpd_pkg::TIMING_TRIM_LSB +: ctpd_pkg::TIMING_TRIM_W];
    assign cfg.sample_oscillator_bypass = sample_q[ctpd_pkg::BYPASS_BIT];
    assign cfg.aux_pin1_output_enable   = pin_q[ctpd_pkg::PIN1_OE_BIT];
    assign cfg.aux_pin1_input_enable    = pin_q[ctpd_pkg::PIN1_IE_BIT];

    // Read mux; unmapped addresses return zero
    always_comb
    begin
        rdata_next = ctpd_pkg::READ_ZERO;
        if (req.rd && req.addr == ctpd_pkg::ADDR_SAMPLE_TRIM)
        begin
            rdata_next = sample_q;
        end
        else if (req.rd && req.addr == ctpd_pkg::ADDR_TIMING_TRIM)
        begin
            rdata_next = timing_q;
        end
        else if (req.rd && req.addr == ctpd_pkg::ADDR_PIN_DIR)
        begin
            rdata_next = pin_q;
        end
    end

    // Oscillator speed code: slow trim runs inverse, so invert to a speed rank
    always_comb
    begin
        speed_next = ~cfg.sample_clock_trim;
        // External clock usable only with pin as pure input
        cfg_ext_next = cfg.sample_oscillator_bypass && cfg.aux_pin1_input_enable
                       && !cfg.aux_pin1_output_enable;
        // Input buffer off gives a quiet low, avoids a floating pin inside
        pin_in_next = cfg.aux_pin1_input_enable & pin_sync2_reg;
    end

    // Registered read data, outputs and pin synchroniser
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            rdata_reg     <= ctpd_pkg::READ_ZERO;
            speed_reg     <= 6'h00;
            cfg_ext_reg   <= 1'b0;
            pin_sync1_reg <= 1'b0;
            pin_sync2_reg <= 1'b0;
            pin_in_reg    <= 1'b0;
            pin_oe_reg    <= 1'b0;
        end
        else
        begin
            rdata_reg     <= rdata_next;
            speed_reg     <= speed_next;
            cfg_ext_reg   <= cfg_ext_next;
            pin_sync1_reg <= aux_pin_one_i;
            pin_sync2_reg <= pin_sync1_reg;
            pin_in_reg    <= pin_in_next;
            pin_oe_reg    <= cfg.aux_pin1_output_enable;
        end
    end

    // Trim codes feed the analog oscillators as is; fast trim runs direct
    assign rdata_o                    = rdata_reg;
    assign sample_clock_trim_o        = cfg.sample_clock_trim;
    assign sample_osc_speed_o         = speed_reg;
    assign timing_clock_trim_o        = cfg.timing_clock_trim;
    assign sample_oscillator_bypass_o = cfg.sample_oscillator_bypass;
    assign sample_clock_ext_ok_o      = cfg_ext_reg;
    // Pin output source select lies elsewhere; driven level is low here
    assign aux_pin_one_o              = 1'b0;
    assign aux_pin_one_oe_o           = pin_oe_reg;
    assign aux_pin_one_in_o           = pin_in_reg;
endmodule : ctpd_top

// File: dv/ctpd_props.sv
// Port checker for the clock trim and pin direction slice
`timescale 1ns/1ns
module ctpd_props (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic [7:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic [5:0]  sample_clock_trim_o,
    input wire logic [5:0]  sample_osc_speed_o,
    input wire logic [7:0]  timing_clock_trim_o,
    input wire logic        sample_oscillator_bypass_o,
    input wire logic        sample_clock_ext_ok_o,
    input wire logic        aux_pin_one_i,
    input wire logic        aux_pin_one_oe_o,
    input wire logic        aux_pin_one_in_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // Field outputs follow a write on the next edge
    slow_trim_a: assert property (wr_i && addr_i == 8'h4b |=> sample_clock_trim_o == $past(wdata_i[5:0]))
        else $error("slow trim write lost");
    fast_trim_a: assert property (wr_i && addr_i == 8'h4d |=> timing_clock_trim_o == $past(wdata_i[7:0]))
        else $error("fast trim write lost");
    bypass_wr_a: assert property (wr_i && addr_i == 8'h4b |=> sample_oscillator_bypass_o == $past(wdata_i[8]))
        else $error("bypass write lost");
    // Gated on a settled reset so the lag flop is not judged on its reset value
    speed_inv_a: assert property (nrst_i && $past(nrst_i) |-> sample_osc_speed_o == ~$past(sample_clock_trim_o))
        else $error("slow speed not inverse of trim");
    wr_rd_a: assert property (wr_i && addr_i == 8'h4d ##1 rd_i && addr_i == 8'h4d |=> rdata_o == $past(wdata_i, 2))
        else $error("read back differs from write");
    oe_track_a: assert property (wr_i && addr_i == 8'h4f ##1 !(wr_i && addr_i == 8'h4f)
        |=> aux_pin_one_oe_o == $past(wdata_i[6], 2)) else $error("output enable wrong");
    ext_ok_a: assert property (sample_clock_ext_ok_o |-> $past(sample_oscillator_bypass_o) && !aux_pin_one_oe_o)
        else $error("external clock flagged while driving");
    in_path_a: assert property (aux_pin_one_in_o |-> $past(aux_pin_one_i, 3))
        else $error("pin input not from pin");
endmodule : ctpd_props
bind ctpd_top ctpd_props u_props (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_clock_trim_o,
    .sample_osc_speed_o, .timing_clock_trim_o, .sample_oscillator_bypass_o, .sample_clock_ext_ok_o, .aux_pin_one_i,
    .aux_pin_one_oe_o, .aux_pin_one_in_o);

// File: dv/tb_top.sv
// Directed register regression for the clock trim slice
`timescale 1ns/1ns
module tb_top;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        aux_pin_one_i = 1'b0;
    logic [15:0] rdata_o;
    logic [5:0]  trim_o;
    logic [5:0]  speed_o;
    logic [7:0]  tim_o;
    logic        byp_o;
    logic        ext_o;
    logic        oe_o;
    logic        pin_o;
    logic        in_o;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [5:0]  sc[3] = '{6'h00, 6'h22, 6'h3f};
    logic [7:0]  tc[3] = '{8'h00, 8'h98, 8'hff};
    ctpd_top uut (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_clock_trim_o(trim_o),
        .sample_osc_speed_o(speed_o), .timing_clock_trim_o(tim_o), .sample_oscillator_bypass_o(byp_o),
        .sample_clock_ext_ok_o(ext_o), .aux_pin_one_i, .aux_pin_one_o(pin_o), .aux_pin_one_oe_o(oe_o),
        .aux_pin_one_in_o(in_o));
    initial forever #5 clk_i = ~clk_i;
    task automatic end_sim();
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    // Hang guard, far above the roughly fifty cycles needed
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // Strobe drops on the edge, next request lands 1 ns later: no double assignment
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : idle
    // Reset values, trim codes, pin modes, unmapped place, mid-run reset
    initial
    begin
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        idle(2);
        rd(8'h4b, ctpd_pkg::SAMPLE_TRIM_RST);
        rd(8'h4d, ctpd_pkg::TIMING_TRIM_RST);
        rd(8'h4f, ctpd_pkg::PIN_DIR_RST);
        chk({10'h000, speed_o}, 16'h002d);
        chk({14'h0000, oe_o, in_o}, 16'h0000);
        foreach (sc[i])
        begin
            wr(8'h4b, {10'h098, sc[i]});
            idle(1);
            chk({10'h000, speed_o}, {10'h000, ~sc[i]});
            rd(8'h4b, {10'h098, sc[i]});
            wr(8'h4d, {8'h00, tc[i]});
            rd(8'h4d, {8'h00, tc[i]});
            chk({8'h00, tim_o}, {8'h00, tc[i]});
        end
        wr(8'h4f, 16'h20d0);
        idle(1);
        // Driver on, level held low while the source select lives elsewhere
        chk({14'h0000, oe_o, pin_o}, 16'h0002);
        wr(8'h4b, 16'h2712);
        wr(8'h4f, 16'h20b0);
        aux_pin_one_i <= 1'b1;
        idle(4);
        chk({13'h0000, byp_o, ext_o, in_o}, 16'h0007);
        wr(8'h4f, 16'h2090);
        idle(2);
        chk({14'h0000, ext_o, in_o}, 16'h0000);
        wr(8'h4c, 16'hffff);
        rd(8'h4c, 16'h0000);
        rd(8'h4b, 16'h2712);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        idle(2);
        rd(8'h4f, ctpd_pkg::PIN_DIR_RST);
        rd(8'h4b, ctpd_pkg::SAMPLE_TRIM_RST);
        chk({8'h00, tim_o}, 16'h0098);
        chk({15'h0000, byp_o}, 16'h0000);
        end_sim();
    end
endmodule : tb_top
